/* File: spi_page_select_and_prescalers.sv */
// page selection, area decode, code decryption and clock prescalers
`default_nettype none
module spi_page_select_and_prescalers
    import spi_page_select_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SPI_WR,
    input wire logic I_SPI_RD,
    input wire logic [ADDR_W-1:0] I_SPI_ADDR,
    input wire logic [DATA_W-1:0] I_SPI_WDATA,
    output area_sel_s O_AREA_SEL,
    output logic O_AREA_WR,
    output logic O_AREA_RD,
    output logic [ADDR_W-1:0] O_AREA_ADDR,
    output logic [DATA_W-1:0] O_AREA_WDATA,
    output logic [DATA_W-1:0] O_CODE_WDATA,
    output logic [DATA_W-1:0] O_RDATA,
    output logic O_RVALID,
    output logic [PAGE_W-1:0] O_PAGE,
    output logic O_CORE_CLOCK_EN,
    output logic O_OFFSET_COMP_CLOCK_EN,
    output logic O_SINGLE_CORE_OK,
    output logic O_DUAL_CORE_OK,
    output logic O_FLAG_DRIVE_OK
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] first,
                                      input logic [ADDR_W-1:0] last);
        in_range = (a >= first) && (a <= last);
    endfunction

    function automatic logic is_code_page(input logic [PAGE_W-1:0] p);
        is_code_page = !p[COMMON_PAGE_BIT] && (p != PAGE_NONE);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [PAGE_W-1:0] page_select;
    logic [CORE_DIV_W-1:0] core_divider_field;
    logic [OFS_DIV_W-1:0] offset_divider_field;
    logic [PAGE_W-1:0] next_page;
    logic page_hit;
    logic page_wr;
    logic local_hit;
    logic access_ok;
    logic read_ok;
    logic code_wr;
    logic cipher_restart;
    logic accept;
    area_sel_s next_area;
    logic [DATA_W-1:0] local_rdata;

    assign page_hit = (I_SPI_ADDR == PAGE_SELECT_ADDR);
    assign page_wr = I_SPI_WR && page_hit;

    always_comb
    begin
        if (I_SPI_WDATA[COMMON_PAGE_BIT])
            next_page = PAGE_COMMON;
        else
            next_page = {1'b0, I_SPI_WDATA[CODE_RAM_TWO_BIT], I_SPI_WDATA[CODE_RAM_ONE_BIT]};
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
            page_select <= PAGE_RESET;
        else if (page_wr)
            page_select <= next_page;
    end

    assign access_ok = (page_select != PAGE_NONE) && !page_hit;
    assign read_ok = access_ok && (page_select != PAGE_CODE_BOTH);
    // refused requests leave the held address and data untouched
    assign accept = (I_SPI_WR && access_ok) || (I_SPI_RD && read_ok);

    // ----------------------------------------------------------------
    // area decode
    // ----------------------------------------------------------------
    // one-hot area selects, except PAGE_CODE_BOTH which sets both code RAM selects
    always_comb
    begin
        next_area = AREA_NONE;
        case (page_select)
            PAGE_CODE_ONE:
                next_area.channel_one_area_selects[AREA_CODE_RAM] = 1'b1;
            PAGE_CODE_TWO:
                next_area.channel_two_area_selects[AREA_CODE_RAM] = 1'b1;
            PAGE_CODE_BOTH:
            begin
                next_area.channel_one_area_selects[AREA_CODE_RAM] = 1'b1;
                next_area.channel_two_area_selects[AREA_CODE_RAM] = 1'b1;
            end
            PAGE_COMMON:
            begin
                next_area.channel_one_area_selects[AREA_DATA_RAM] =
                    in_range(I_SPI_ADDR, DRAM_ONE_FIRST, DRAM_ONE_LAST);
                next_area.channel_two_area_selects[AREA_DATA_RAM] =
                    in_range(I_SPI_ADDR, DRAM_TWO_FIRST, DRAM_TWO_LAST);
                next_area.channel_one_area_selects[AREA_CFG] =
                    in_range(I_SPI_ADDR, CFG_ONE_FIRST, CFG_ONE_LAST);
                next_area.channel_two_area_selects[AREA_CFG] =
                    in_range(I_SPI_ADDR, CFG_TWO_FIRST, CFG_TWO_LAST);
                next_area.io_cfg = in_range(I_SPI_ADDR, IO_CFG_FIRST, IO_CFG_LAST);
                // prescaler registers live here and are not forwarded
                next_area.main_cfg = in_range(I_SPI_ADDR, MAIN_CFG_FIRST, MAIN_CFG_LAST) && !local_hit;
                next_area.diag_cfg = in_range(I_SPI_ADDR, DIAG_CFG_FIRST, DIAG_CFG_LAST);
            end
            default:
                next_area = AREA_NONE;
        endcase
    end

    assign local_hit = (page_select == PAGE_COMMON) &&
                       ((I_SPI_ADDR == CORE_DIV_ADDR) || (I_SPI_ADDR == OFS_DIV_ADDR));

    // ----------------------------------------------------------------
    // area strobes, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_AREA_SEL <= AREA_NONE;
            O_AREA_WR <= 1'b0;
            O_AREA_RD <= 1'b0;
        end
        else
        begin
            O_AREA_WR <= I_SPI_WR && access_ok && !local_hit;
            O_AREA_RD <= I_SPI_RD && read_ok && !local_hit;
            if (accept)
                O_AREA_SEL <= next_area;
            else
                O_AREA_SEL <= AREA_NONE;
        end
    end

    // request copy held until the next accepted access
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_AREA_ADDR <= '0;
            O_AREA_WDATA <= '0;
        end
        else if (accept)
        begin
            O_AREA_ADDR <= I_SPI_ADDR;
            O_AREA_WDATA <= I_SPI_WDATA;
        end
    end

    // ----------------------------------------------------------------
    // code decryption
    // ----------------------------------------------------------------
    // storing zero or four leaves the keystream where it stood
    // restart on code page write
    assign cipher_restart = page_wr && is_code_page(next_page);
    assign code_wr = I_SPI_WR && access_ok && is_code_page(page_select);

    code_cipher u_cipher (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_restart(cipher_restart),
        .i_advance(code_wr),
        .i_data(I_SPI_WDATA),
        .o_data(O_CODE_WDATA)
    );

    // ----------------------------------------------------------------
    // prescaler registers, on the system clock
    // ----------------------------------------------------------------
    // register file on system clock
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            core_divider_field <= CORE_DIV_RESET;
            offset_divider_field <= OFS_DIV_RESET;
        end
        else if (I_SPI_WR && local_hit)
        begin
            if (I_SPI_ADDR == CORE_DIV_ADDR)
                core_divider_field <= I_SPI_WDATA[CORE_DIV_W-1:0];
            else
                offset_divider_field <= I_SPI_WDATA[OFS_DIV_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // local read-back
    // ----------------------------------------------------------------
    always_comb
    begin
        local_rdata = '0;
        if (page_hit)
            local_rdata[PAGE_W-1:0] = page_select;
        else if (I_SPI_ADDR == CORE_DIV_ADDR)
            local_rdata[CORE_DIV_W-1:0] = core_divider_field;
        else
            local_rdata[OFS_DIV_W-1:0] = offset_divider_field;
    end

    // page register read on any page
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_RDATA <= '0;
            O_RVALID <= 1'b0;
        end
        else
        begin
            O_RVALID <= I_SPI_RD && (page_hit || local_hit);
            if (I_SPI_RD && (page_hit || local_hit))
                O_RDATA <= local_rdata;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
            O_PAGE <= PAGE_RESET;
        else if (page_wr)
            O_PAGE <= next_page;
    end

    // ----------------------------------------------------------------
    // prescalers
    // ----------------------------------------------------------------
    // core enable, divide by field plus one
    // channel blocks gated by this enable
    clock_prescaler #(
        .W(CORE_DIV_W)
    ) u_core_prescaler (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_ratio(core_divider_field),
        .o_tick(O_CORE_CLOCK_EN)
    );

    // offset enable, divide by field plus one
    clock_prescaler #(
        .W(OFS_DIV_W)
    ) u_offset_prescaler (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_ratio(offset_divider_field),
        .o_tick(O_OFFSET_COMP_CLOCK_EN)
    );

    // ----------------------------------------------------------------
    // operating modes allowed by the core divider
    // ----------------------------------------------------------------
    // enable levels only; the cores that obey them sit elsewhere
    // divider thresholds for modes
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_SINGLE_CORE_OK <= 1'b0;
            O_DUAL_CORE_OK <= 1'b0;
            O_FLAG_DRIVE_OK <= 1'b0;
        end
        else
        begin
            O_SINGLE_CORE_OK <= core_divider_field >= SINGLE_CORE_MIN_DIV;
            O_FLAG_DRIVE_OK <= core_divider_field >= SINGLE_CORE_MIN_DIV;
            O_DUAL_CORE_OK <= core_divider_field >= DUAL_CORE_MIN_DIV;
        end
    end
endmodule
`default_nettype wire

/* File: spi_page_select_pkg.sv */
// constants and carrier types shared by the page-select and prescaler logic
`default_nettype none
package spi_page_select_pkg;
    // ----------------------------------------------------------------
    // bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 3;
    localparam int CORE_DIV_W = 6;
    localparam int OFS_DIV_W = 8;

    // ----------------------------------------------------------------
    // register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PAGE_SELECT_ADDR = 10'h3FF;
    localparam logic [ADDR_W-1:0] CORE_DIV_ADDR = 10'h1C0;
    localparam logic [ADDR_W-1:0] OFS_DIV_ADDR = 10'h1C4;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;
    localparam logic [CORE_DIV_W-1:0] CORE_DIV_RESET = 6'h00;
    localparam logic [OFS_DIV_W-1:0] OFS_DIV_RESET = 8'h00;

    // ----------------------------------------------------------------
    // page-select fields and values
    // ----------------------------------------------------------------
    localparam int COMMON_PAGE_BIT = 2;
    localparam int CODE_RAM_TWO_BIT = 1;
    localparam int CODE_RAM_ONE_BIT = 0;
    localparam logic [PAGE_W-1:0] PAGE_NONE = 3'h0;
    localparam logic [PAGE_W-1:0] PAGE_CODE_ONE = 3'h1;
    localparam logic [PAGE_W-1:0] PAGE_CODE_TWO = 3'h2;
    localparam logic [PAGE_W-1:0] PAGE_CODE_BOTH = 3'h3;
    localparam logic [PAGE_W-1:0] PAGE_COMMON = 3'h4;

    // ----------------------------------------------------------------
    // common-page address map, inclusive ranges
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] DRAM_ONE_FIRST = 10'h000;
    localparam logic [ADDR_W-1:0] DRAM_ONE_LAST = 10'h07F;
    localparam logic [ADDR_W-1:0] DRAM_TWO_FIRST = 10'h080;
    localparam logic [ADDR_W-1:0] DRAM_TWO_LAST = 10'h0FF;
    localparam logic [ADDR_W-1:0] CFG_ONE_FIRST = 10'h100;
    localparam logic [ADDR_W-1:0] CFG_ONE_LAST = 10'h13F;
    localparam logic [ADDR_W-1:0] CFG_TWO_FIRST = 10'h140;
    localparam logic [ADDR_W-1:0] CFG_TWO_LAST = 10'h17F;
    localparam logic [ADDR_W-1:0] IO_CFG_FIRST = 10'h180;
    localparam logic [ADDR_W-1:0] IO_CFG_LAST = 10'h1BF;
    localparam logic [ADDR_W-1:0] MAIN_CFG_FIRST = 10'h1C0;
    localparam logic [ADDR_W-1:0] MAIN_CFG_LAST = 10'h1FF;
    localparam logic [ADDR_W-1:0] DIAG_CFG_FIRST = 10'h200;
    localparam logic [ADDR_W-1:0] DIAG_CFG_LAST = 10'h3FE;

    // ----------------------------------------------------------------
    // operating-mode thresholds on the core divider field
    // ----------------------------------------------------------------
    localparam logic [CORE_DIV_W-1:0] SINGLE_CORE_MIN_DIV = 6'h01;
    localparam logic [CORE_DIV_W-1:0] DUAL_CORE_MIN_DIV = 6'h03;

    // ----------------------------------------------------------------
    // cipher keystream, values arbitrary
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] CIPHER_SEED = 16'hA5C3;
    localparam logic [DATA_W-1:0] CIPHER_TAPS = 16'hB400;

    // ----------------------------------------------------------------
    // area selects
    // ----------------------------------------------------------------
    localparam int AREA_DATA_RAM = 0;
    localparam int AREA_CODE_RAM = 1;
    localparam int AREA_CFG = 2;

    typedef struct packed {
        logic [2:0] channel_one_area_selects;
        logic [2:0] channel_two_area_selects;
        logic main_cfg;
        logic io_cfg;
        logic diag_cfg;
    } area_sel_s;

    localparam area_sel_s AREA_NONE = '{3'h0, 3'h0, 1'b0, 1'b0, 1'b0};
endpackage
`default_nettype wire

/* File: clock_prescaler.sv */
// counter prescaler emitting a one-cycle enable every ratio+1 system clocks
`default_nettype none
module clock_prescaler #(
    parameter int W = 6
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_ratio,
    output logic o_tick
);
    logic [W-1:0] count;
    logic [W-1:0] ratio;

    // ----------------------------------------------------------------
    // count and wrap
    // ----------------------------------------------------------------
    // new ratio at wrap
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            count <= '0;
            ratio <= '0;
            o_tick <= 1'b0;
        end
        else if (count >= ratio)
        begin
            count <= '0;
            ratio <= i_ratio;
            o_tick <= 1'b1;
        end
        else
        begin
            count <= count + W'(1);
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: code_cipher.sv */
// keystream decryption of code words, restartable from its seed
`default_nettype none
module code_cipher
    import spi_page_select_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_restart,
    input wire logic i_advance,
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data
);
    logic [DATA_W-1:0] key;

    // ----------------------------------------------------------------
    // keystream state
    // ----------------------------------------------------------------
    // restart from seed
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_restart)
            key <= CIPHER_SEED;
        else if (i_advance)
            key <= {1'b0, key[DATA_W-1:1]} ^ (key[0] ? CIPHER_TAPS : '0);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_data <= '0;
        else if (i_advance)
            o_data <= i_data ^ key;
    end
endmodule
`default_nettype wire

/* File: spi_page_select_chk.sv */
// concurrent checks on the page-select, area decode, decryption and prescaler ports
`default_nettype none
module spi_page_select_chk
    import spi_page_select_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SPI_WR,
    input wire logic I_SPI_RD,
    input wire logic [ADDR_W-1:0] I_SPI_ADDR,
    input wire logic [DATA_W-1:0] I_SPI_WDATA,
    input wire area_sel_s O_AREA_SEL,
    input wire logic O_AREA_WR,
    input wire logic O_AREA_RD,
    input wire logic [DATA_W-1:0] O_CODE_WDATA,
    input wire logic [DATA_W-1:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic [PAGE_W-1:0] O_PAGE,
    input wire logic O_CORE_CLOCK_EN,
    input wire logic O_OFFSET_COMP_CLOCK_EN,
    input wire logic O_SINGLE_CORE_OK,
    input wire logic O_DUAL_CORE_OK,
    input wire logic O_FLAG_DRIVE_OK
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] core_gap;
    logic [8:0] ofs_gap;
    logic page_hit;
    logic common_req;
    logic code_cmd;
    logic [PAGE_W-1:0] page_exp;
    area_sel_s dec_sel;

    function automatic area_sel_s exp_sel(input logic [ADDR_W-1:0] a);
        area_sel_s s;
        s = AREA_NONE;
        if (a <= DRAM_ONE_LAST)
            s.channel_one_area_selects = 3'h1;
        else if (a <= DRAM_TWO_LAST)
            s.channel_two_area_selects = 3'h1;
        else if (a <= CFG_ONE_LAST)
            s.channel_one_area_selects = 3'h4;
        else if (a <= CFG_TWO_LAST)
            s.channel_two_area_selects = 3'h4;
        else if (a <= IO_CFG_LAST)
            s.io_cfg = 1'b1;
        else if (a <= MAIN_CFG_LAST)
            s.main_cfg = 1'b1;
        else
            s.diag_cfg = 1'b1;
        return s;
    endfunction

    assign page_hit = I_SPI_ADDR == PAGE_SELECT_ADDR;
    assign common_req = O_PAGE == PAGE_COMMON && (I_SPI_WR || I_SPI_RD);
    assign code_cmd = I_SPI_WR && page_hit && !I_SPI_WDATA[COMMON_PAGE_BIT] && I_SPI_WDATA[1:0] != 2'h0;
    assign page_exp = I_SPI_WDATA[COMMON_PAGE_BIT] ? PAGE_COMMON : {1'b0, I_SPI_WDATA[1:0]};
    assign dec_sel = exp_sel(I_SPI_ADDR);

    // cycles since the last enable; a stuck or too slow prescaler overruns these
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST || O_CORE_CLOCK_EN)
            core_gap <= 8'h00;
        else
            core_gap <= core_gap + 8'h01;
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST || O_OFFSET_COMP_CLOCK_EN)
            ofs_gap <= 9'h000;
        else
            ofs_gap <= ofs_gap + 9'h001;
    end

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    reset_state_a: assert property ($fell(I_RST) |-> O_PAGE == PAGE_RESET && O_AREA_SEL == AREA_NONE
        && !O_AREA_WR && !O_RVALID) else $error("outputs not cleared by reset");
    page_store_a: assert property (I_SPI_WR && page_hit |=> O_PAGE == $past(page_exp))
        else $error("page register stored wrong value");
    page_read_a: assert property (I_SPI_RD && page_hit |=> O_RVALID && O_RDATA == {13'h0000, O_PAGE})
        else $error("page register read failed");
    page_zero_quiet_a: assert property (O_PAGE == PAGE_NONE && (I_SPI_WR || I_SPI_RD)
        |=> O_AREA_SEL == AREA_NONE && !O_AREA_WR && !O_AREA_RD) else $error("access forwarded on page zero");
    both_no_read_a: assert property (O_PAGE == PAGE_CODE_BOTH && I_SPI_RD
        |=> !O_AREA_RD && O_AREA_SEL == AREA_NONE) else $error("read forwarded on dual code page");
    both_write_a: assert property (O_PAGE == PAGE_CODE_BOTH && I_SPI_WR && !page_hit
        |=> O_AREA_WR && O_AREA_SEL == 9'h090) else $error("dual code write not sent to both");
    code_route_a: assert property ((O_PAGE == PAGE_CODE_ONE || O_PAGE == PAGE_CODE_TWO)
        && (I_SPI_WR || I_SPI_RD) && !page_hit
        |=> O_AREA_SEL == (($past(O_PAGE) == PAGE_CODE_ONE) ? 9'h080 : 9'h010)) else $error("code page routed wrong");
    cipher_restart_a: assert property (code_cmd ##1 (I_SPI_WR && !page_hit)
        |=> O_AREA_WR && O_CODE_WDATA == ($past(I_SPI_WDATA) ^ CIPHER_SEED)) else $error("cipher not restarted");
    area_decode_a: assert property (common_req && !page_hit && I_SPI_ADDR != CORE_DIV_ADDR
        && I_SPI_ADDR != OFS_DIV_ADDR |=> O_AREA_SEL == $past(dec_sel)) else $error("area select decoded wrong");
    local_regs_a: assert property (common_req && (I_SPI_ADDR == CORE_DIV_ADDR || I_SPI_ADDR == OFS_DIV_ADDR)
        |=> O_AREA_SEL == AREA_NONE && !O_AREA_WR && !O_AREA_RD) else $error("divider access forwarded");
    core_gap_a: assert property (core_gap < 8'h40)
        else $error("core enable gap too long");
    ofs_gap_a: assert property (ofs_gap < 9'h100)
        else $error("offset enable gap too long");
    mode_levels_a: assert property (O_FLAG_DRIVE_OK == O_SINGLE_CORE_OK
        && (!O_DUAL_CORE_OK || O_SINGLE_CORE_OK)) else $error("mode levels inconsistent");

    cover property (code_cmd ##1 I_SPI_WR);
    cover property (O_PAGE == PAGE_CODE_BOTH && I_SPI_WR);
    cover property (O_CORE_CLOCK_EN && core_gap > 8'h03);
    cover property (O_RVALID && O_DUAL_CORE_OK);
endmodule

bind spi_page_select_and_prescalers spi_page_select_chk chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_SPI_WR(I_SPI_WR), .I_SPI_RD(I_SPI_RD),
    .I_SPI_ADDR(I_SPI_ADDR), .I_SPI_WDATA(I_SPI_WDATA), .O_AREA_SEL(O_AREA_SEL), .O_AREA_WR(O_AREA_WR),
    .O_AREA_RD(O_AREA_RD), .O_CODE_WDATA(O_CODE_WDATA), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
    .O_PAGE(O_PAGE), .O_CORE_CLOCK_EN(O_CORE_CLOCK_EN), .O_OFFSET_COMP_CLOCK_EN(O_OFFSET_COMP_CLOCK_EN),
    .O_SINGLE_CORE_OK(O_SINGLE_CORE_OK), .O_DUAL_CORE_OK(O_DUAL_CORE_OK), .O_FLAG_DRIVE_OK(O_FLAG_DRIVE_OK)
);
`default_nettype wire

/* File: spi_host_model.sv */
// request-port model of the host microcontroller
`default_nettype none
module spi_host_model
    import spi_page_select_pkg::*;
(
    input wire logic i_clk,
    output var logic o_wr,
    output var logic o_rd,
    output var logic [ADDR_W-1:0] o_addr,
    output var logic [DATA_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 10'h000;
        o_data = 16'h0000;
    end

    // code words go out exactly as handed over, already enciphered
    // one request per call on a rising edge: kind 1 write, 2 read, else idle
    task automatic req(input int kind, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        o_wr <= (kind == 1);
        o_rd <= (kind == 2);
        // released lines toggle so a stale value never looks live
        o_addr <= (kind == 1 || kind == 2) ? a : ~o_addr;
        o_data <= (kind == 1) ? d : ~o_data;
    endtask
endmodule
`default_nettype wire

/* File: spi_page_select_and_prescalers_bench.sv */
// self-checking bench for page selection, decode, decryption and prescalers
`default_nettype none
module spi_page_select_and_prescalers_bench
    import spi_page_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr, rd, awr, ard, rvalid, cen, oen, sok, dok, fok;
    logic [ADDR_W-1:0] addr, aaddr;
    logic [DATA_W-1:0] wdata, awdata, cwdata, rdata;
    logic [PAGE_W-1:0] page;
    area_sel_s sel;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    spi_host_model host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_data(wdata));

    spi_page_select_and_prescalers uut (
        .I_SYS_CLK(clk), .I_RST(rst), .I_SPI_WR(wr), .I_SPI_RD(rd), .I_SPI_ADDR(addr), .I_SPI_WDATA(wdata),
        .O_AREA_SEL(sel), .O_AREA_WR(awr), .O_AREA_RD(ard), .O_AREA_ADDR(aaddr), .O_AREA_WDATA(awdata),
        .O_CODE_WDATA(cwdata), .O_RDATA(rdata), .O_RVALID(rvalid), .O_PAGE(page), .O_CORE_CLOCK_EN(cen),
        .O_OFFSET_COMP_CLOCK_EN(oen), .O_SINGLE_CORE_OK(sok), .O_DUAL_CORE_OK(dok), .O_FLAG_DRIVE_OK(fok)
    );

    function automatic logic [PAGE_W-1:0] exp_page(input logic [DATA_W-1:0] v);
        return v[2] ? PAGE_COMMON : {1'b0, v[1:0]};
    endfunction

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request, then idle; answers are sampled mid-cycle after the taking edge
    task automatic xfer(input int kind, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        host.req(kind, a, d);
        host.req(0, a, d);
        @(negedge clk);
    endtask

    // cycles between the second and third enables seen from now
    task automatic tick_gap(input bit ofs, output int n);
        int k;
        k = 0;
        n = 0;
        while (k < 3 && n < 600)
        begin
            @(negedge clk);
            n++;
            if ((ofs ? oen : cen) === 1'b1)
            begin
                k++;
                if (k < 3)
                    n = 0;
            end
        end
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    initial
    begin
        logic [15:0] d;
        logic [9:0] a;
        int k, n, v;
        void'($urandom(5));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        xfer(2, PAGE_SELECT_ADDR, 16'h0000);
        chk({13'h0000, page}, 16'h0000);
        chk(rdata, 16'h0000);
        repeat (8)
        begin
            xfer($urandom_range(1, 2), 10'($urandom_range(0, 1022)), 16'($urandom));
            chk({5'h00, awr, ard, sel}, 16'h0000);
        end
        $display("reset and page zero done");
        for (v = 0; v < 8; v++)
        begin
            d = {13'($urandom), 3'(v)};
            xfer(1, PAGE_SELECT_ADDR, d);
            chk({13'h0000, page}, {13'h0000, exp_page(d)});
            xfer(2, PAGE_SELECT_ADDR, 16'h0000);
            chk(rdata, {13'h0000, exp_page(d)});
            chk({15'h0000, rvalid}, 16'h0001);
        end
        $display("page values done");
        for (v = 1; v < 4; v++)
        begin
            a = 10'($urandom_range(0, 1021));
            d = 16'($urandom);
            host.req(1, PAGE_SELECT_ADDR, 16'(v));
            xfer(1, a, d);
            chk({13'h0000, awr, sel.channel_two_area_selects[1], sel.channel_one_area_selects[1]}, 16'(v + 4));
            chk(cwdata, d ^ CIPHER_SEED);
            xfer(1, a + 10'h001, d);
            chk({15'h0000, cwdata === (d ^ CIPHER_SEED)}, 16'h0000);
            xfer(2, a, 16'h0000);
            chk({15'h0000, ard}, {15'h0000, v != 3});
        end
        $display("code pages done");
        xfer(1, PAGE_SELECT_ADDR, 16'h0004);
        repeat (24)
        begin
            k = $urandom_range(1, 2);
            a = 10'($urandom_range(0, 1022));
            if (a == CORE_DIV_ADDR || a == OFS_DIV_ADDR)
                a = DIAG_CFG_LAST;
            d = 16'($urandom);
            xfer(k, a, d);
            chk({6'h00, aaddr}, {6'h00, a});
            chk({14'h0000, awr, ard}, {14'h0000, k == 1, k == 2});
            chk({15'h0000, sel != AREA_NONE}, 16'h0001);
            if (k == 1)
                chk(awdata, d);
        end
        $display("common page done");
        for (k = 0; k < 6; k++)
        begin
            v = (k < 5) ? k : $urandom_range(5, 63);
            xfer(1, CORE_DIV_ADDR, {10'($urandom), 6'(v)});
            xfer(2, CORE_DIV_ADDR, 16'h0000);
            chk(rdata, 16'(v));
            chk({13'h0000, sok, fok, dok}, {13'h0000, v >= 1, v >= 1, v >= 3});
            tick_gap(1'b0, n);
            chk(16'(n), 16'(v + 1));
        end
        for (k = 0; k < 3; k++)
        begin
            v = (k == 0) ? 8 : (k == 1) ? 0 : $urandom_range(1, 255);
            xfer(1, OFS_DIV_ADDR, {8'($urandom), 8'(v)});
            xfer(2, OFS_DIV_ADDR, 16'h0000);
            chk(rdata, 16'(v));
            tick_gap(1'b1, n);
            chk(16'(n), 16'(v + 1));
        end
        $display("prescalers done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick_gap(1'b0, n);
        chk({13'h0000, page}, 16'h0000);
        chk(16'(n), 16'h0001);
        $display("second reset done");
        test_done();
    end
endmodule
`default_nettype wire
